/* File: rtl/cfp_pkg.sv */
// constants, register map and carrier types for the converter fault protection block
package cfp_pkg;
  localparam int CLK_NS = 5;
  localparam int T_BUCK_ILIM_NS = 20000;
  localparam int T_BOOST_CURRENT_LIMIT_SEL_NS = 64000;
  localparam int T_MS_NS = 1000000;
  localparam int T_THERM_NS = 20000;
  localparam int T_OVP_NS = 1000;
  localparam int T_PG_BUCK_NS = 6000;
  localparam int T_PG_MON_NS = 15000;
  localparam int BUCK_ILIM_CYC = (T_BUCK_ILIM_NS + CLK_NS - 1) / CLK_NS;
  localparam int BOOST_CURRENT_LIMIT_SEL_CYC = (T_BOOST_CURRENT_LIMIT_SEL_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_CYC = (T_MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int THERM_CYC = (T_THERM_NS + CLK_NS - 1) / CLK_NS;
  localparam int OVP_CYC = (T_OVP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PG_BUCK_CYC = (T_PG_BUCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PG_MON_CYC = (T_PG_MON_NS + CLK_NS - 1) / CLK_NS;
  localparam int CW = 18;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INT_CONV = 8'h01;
  localparam logic [7:0] A_INT_TOP = 8'h02;
  localparam logic [7:0] A_MASK_CONV = 8'h03;
  localparam logic [7:0] A_MASK_TOP = 8'h04;
  localparam logic [7:0] A_STAT = 8'h05;
  localparam logic [7:0] A_STAT2 = 8'h06;
  localparam logic [7:0] A_GPO = 8'h07;
  localparam logic [7:0] A_GPO_SEQ = 8'h08;
  localparam logic [7:0] A_PG_STAT = 8'h09;
  localparam logic [7:0] CTRL_RST = 8'h70;
  localparam logic [7:0] TOP_RST = 8'h08;
  localparam int SOFTWARE_RESET_REQUEST_BIT = 7;
  localparam int TF_WARN = 0;
  localparam int TF_OVP = 1;
  localparam int TF_TSD = 2;
  localparam int TF_RST = 3;
  localparam int TF_BUCKG = 4;
  localparam int TF_BOOSTG = 5;
  localparam int TF_SED = 6;
  localparam int TF_DED = 7;
  localparam int DB_ILIM = 0;
  localparam int DB_OVL = 3;
  localparam int DB_WARN = 5;
  localparam int DB_TSD = 6;
  localparam int DB_OVP = 7;
  localparam int DB_PGB = 8;
  localparam int DB_PGM = 10;
  localparam int NDB = 14;
  typedef enum logic [1:0] {ST_SHUTDOWN = 2'b00, ST_STANDBY = 2'b01, ST_ACTIVE = 2'b10} cfp_state_e;
  typedef struct packed {
    logic software_reset_request;
    logic [2:0] discharge;
    logic warn_sel;
    logic [2:0] enable;
  } cfp_ctrl_s;
  typedef struct packed {
    logic out2_function_select;
    logic out1_function_select;
    logic [2:0] drive_type;
    logic [2:0] level;
  } cfp_gpo_s;
  typedef struct packed {
    logic [2:0] current_limit;
    logic [1:0] buck_low;
    logic boost_sag;
    logic boost_low;
    logic [1:0] vout_ramp;
    logic warn_hi;
    logic warn_lo;
    logic thermal_sd;
    logic overvoltage;
    logic uvlo;
    logic enable_pin;
    logic [1:0] pg_buck;
    logic [3:0] pg_mon;
  } cfp_pins_s;
endpackage

/* File: rtl/cfp_top.sv */
// converter fault supervision, warning flags, interrupt pin and general outputs
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - buck current limit 20us sets flag
// - no current limit flag during start/ramp
// - buck below short level disables, sets flag
// - boost current limit 64us sets flag
// - boost sag: off after 1ms; low stops
// - startup check of output after 1ms
// - buck overload 1ms disables converter
// - shutdown sets short, group flags, clears running
// - write 1 clears short flag, restarts
// - thermal warning per selected threshold sets flag
// - live warn status, clear, mask
// - discharge only when its enable set
// - overvoltage: all off, outputs low except pin 1 carrying power-good, flag
// - overvoltage flag sticky while condition persists
// - thermal shutdown: all off, flag, standby
// - shutdown flag sticky, blocks enabling
// - lockout: off, discharge, shutdown state
// - lockout/soft reset: defaults, reset flag
// - single and double error flags
// - three outputs, muxed pins, drive, level
// - outputs follow enable pin when selected
// - filtered inputs by counter, enable synced
module cfp_top #(
  parameter int ILIM_BOOST_CYCLES = cfp_pkg::BOOST_CURRENT_LIMIT_SEL_CYC,
  parameter int MS_CYCLES = cfp_pkg::MS_CYC
) (
  input wire logic i_clk, // system clock
  input wire logic i_resetn, // async reset, active low
  input wire cfp_pkg::cfp_pins_s i_pins, // comparator and pin levels
  input wire logic i_pg1_level, // power-good level for shared pin 1
  input wire logic i_ecc_single, // corrected single error pulse
  input wire logic i_ecc_double, // double error pulse
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  output logic [2:0] o_conv_enable, // buck0, buck1, boost running
  output logic [2:0] o_discharge, // output pulldown enable
  output logic o_boost_switch_stop, // boost switching halted
  output logic o_irq_out_low_o, // interrupt pin drive value
  output logic o_irq_out_low_oe, // interrupt pin pulled low
  output logic [2:0] o_gpo_o, // general output drive value
  output logic [2:0] o_gpo_oe // general output enable
);
  import cfp_pkg::*;

  localparam logic [CW-1:0] MS_TOP = CW'(MS_CYCLES);
  localparam logic [CW-1:0] MS_LAST = CW'(MS_CYCLES - 1);
  localparam logic [CW-1:0] ONE = 18'h00001;

  cfp_pins_s sync1;
  cfp_pins_s pin;
  cfp_ctrl_s ctrl;
  cfp_gpo_s gpo;
  cfp_state_e state;
  cfp_state_e next_state;
  logic [2:0] seq_ctrl;
  logic swrst;
  logic [5:0] conv_flag;
  logic [5:0] conv_mask;
  logic [7:0] top_flag;
  logic [7:0] top_mask;
  logic [NDB-1:0] db_raw;
  logic [NDB-1:0] db;
  logic [NDB-1:0] db_q;
  logic [CW-1:0] db_cnt [NDB];
  logic [CW-1:0] su_cnt [3];
  logic [CW-1:0] bd_cnt;
  logic [2:0] run;
  logic [2:0] allow;
  logic [2:0] starting;
  logic [2:0] check;
  logic [2:0] fault;
  logic [2:0] low_now;
  logic [2:0] ilim_set;
  logic [2:0] prot_off;
  logic [2:0] gv;
  logic [7:0] top_set;
  logic [5:0] conv_clr;
  logic [7:0] top_clr;
  logic reg_clear;
  logic shutdown;
  logic ovp_live;
  logic tsd_live;
  logic ovp_block;
  logic pending;

  function automatic logic [CW-1:0] db_limit(input int idx, input logic rising);
    logic [CW-1:0] lim;
    lim = CW'(BUCK_ILIM_CYC);
    if (idx == DB_ILIM + 2)
      lim = CW'(ILIM_BOOST_CYCLES);
    else if (idx >= DB_OVL && idx < DB_WARN)
      // overload has no release filter: it drops at once
      lim = rising ? CW'(MS_CYCLES) : ONE;
    else if (idx == DB_WARN || idx == DB_TSD)
      lim = CW'(THERM_CYC);
    else if (idx == DB_OVP)
      lim = CW'(OVP_CYC);
    else if (idx >= DB_PGB && idx < DB_PGM)
      lim = CW'(PG_BUCK_CYC);
    else if (idx >= DB_PGM)
      lim = CW'(PG_MON_CYC);
    return lim;
  endfunction

  function automatic logic [CW-1:0] inc_sat(input logic [CW-1:0] c);
    return (c == MS_TOP) ? c : c + ONE;
  endfunction

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1 <= '0;
      pin <= '0;
    end
    else
    begin
      sync1 <= i_pins;
      pin <= sync1;
    end
  end

  assign db_raw = {pin.pg_mon, pin.pg_buck, pin.overvoltage, pin.thermal_sd,
                   ctrl.warn_sel ? pin.warn_hi : pin.warn_lo, pin.buck_low, pin.current_limit};

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      db <= '0;
      db_q <= '0;
      for (int i = 0; i < NDB; i++)
        db_cnt[i] <= '0;
    end
    else
    begin
      db_q <= db;
      for (int i = 0; i < NDB; i++)
      begin
        if (db_raw[i] == db[i])
          db_cnt[i] <= '0;
        else if (db_cnt[i] + ONE >= db_limit(i, db_raw[i]))
        begin
          db[i] <= db_raw[i];
          db_cnt[i] <= '0;
        end
        else
          db_cnt[i] <= db_cnt[i] + ONE;
      end
    end
  end

  // lockout or soft reset clears registers
  assign reg_clear = pin.uvlo | swrst;
  assign shutdown = (state == ST_SHUTDOWN);
  // over-voltage is watched only in standby and active
  assign ovp_live = db[DB_OVP] & ~shutdown;
  assign tsd_live = db[DB_TSD];
  // enabling blocked by live or pending faults
  // thermal block on live or pending
  assign ovp_block = ovp_live | top_flag[TF_OVP] | tsd_live | top_flag[TF_TSD] | shutdown;
  // cleared short flag lets it start again
  assign allow = ctrl.enable & ~conv_flag[5:3] & {3{~ovp_block}};
  assign low_now = {pin.boost_sag, pin.buck_low};

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      starting[i] = run[i] & (su_cnt[i] != MS_TOP);
      check[i] = run[i] & (su_cnt[i] == MS_LAST);
    end
    fault[0] = (check[0] & low_now[0]) | (run[0] & ~starting[0] & db[DB_OVL]);
    fault[1] = (check[1] & low_now[1]) | (run[1] & ~starting[1] & db[DB_OVL + 1]);
    fault[2] = (check[2] & low_now[2]) | (run[2] & (bd_cnt == MS_LAST));
    ilim_set[1:0] = run[1:0] & db[1:0] & ~db_q[1:0] & ~starting[1:0] & ~pin.vout_ramp;
    ilim_set[2] = run[2] & db[2] & ~db_q[2] & ~starting[2];
    prot_off = (ctrl.enable & ~allow) | fault | {3{shutdown}};
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      run <= 3'h0;
      bd_cnt <= '0;
      for (int i = 0; i < 3; i++)
        su_cnt[i] <= '0;
    end
    else
    begin
      run <= reg_clear ? 3'h0 : (allow & ~fault);
      for (int i = 0; i < 3; i++)
        su_cnt[i] <= run[i] ? inc_sat(su_cnt[i]) : '0;
      bd_cnt <= (run[2] & pin.boost_sag) ? inc_sat(bd_cnt) : '0;
    end
  end

  assign o_conv_enable = run;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_discharge <= 3'h0;
      o_boost_switch_stop <= 1'b0;
    end
    else
    begin
      o_discharge <= prot_off & ctrl.discharge;
      o_boost_switch_stop <= run[2] & pin.boost_low;
    end
  end

  assign conv_clr = (i_wr && i_addr == A_INT_CONV) ? i_wdata[5:0] : 6'h00;
  assign top_clr = (i_wr && i_addr == A_INT_TOP) ? i_wdata : 8'h00;
  assign top_set = {i_ecc_double, i_ecc_single, fault[2], |fault[1:0], 1'b0,
                    tsd_live, ovp_live, db[DB_WARN] & ~db_q[DB_WARN]};

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      conv_flag <= 6'h00;
      top_flag <= TOP_RST;
    end
    else if (reg_clear)
    begin
      conv_flag <= 6'h00;
      top_flag <= TOP_RST;
    end
    else
    begin
      conv_flag <= (conv_flag & ~conv_clr) | {fault, ilim_set};
      top_flag <= (top_flag & ~top_clr) | top_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl <= CTRL_RST;
      conv_mask <= 6'h00;
      top_mask <= 8'h00;
      gpo <= '0;
      seq_ctrl <= 3'h0;
    end
    else if (reg_clear)
    begin
      ctrl <= CTRL_RST;
      conv_mask <= 6'h00;
      top_mask <= 8'h00;
      gpo <= '0;
      seq_ctrl <= 3'h0;
    end
    else if (i_wr)
    begin
      case (i_addr)
        A_CTRL: ctrl <= {1'b0, i_wdata[6:0]};
        A_MASK_CONV: conv_mask <= i_wdata[5:0];
        A_MASK_TOP: top_mask <= i_wdata;
        A_GPO: gpo <= i_wdata;
        A_GPO_SEQ: seq_ctrl <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  // soft reset is a one-cycle pulse; the request bit itself never stores
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      swrst <= 1'b0;
    else
      swrst <= i_wr & (i_addr == A_CTRL) & i_wdata[SOFTWARE_RESET_REQUEST_BIT];
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_SHUTDOWN:
        if (!pin.uvlo)
          next_state = ST_STANDBY;
      ST_STANDBY:
        if (pin.uvlo)
          next_state = ST_SHUTDOWN;
        else if (|run)
          next_state = ST_ACTIVE;
      ST_ACTIVE:
        if (pin.uvlo)
          next_state = ST_SHUTDOWN;
        else if (!(|run))
          next_state = ST_STANDBY;
      default:
        next_state = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state <= ST_STANDBY;
    else
      state <= next_state;
  end

  // mask keeps flag off the pin
  // pin low while unmasked flag pending
  assign pending = (|(conv_flag & ~conv_mask)) | (|(top_flag & ~top_mask));

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_irq_out_low_o <= 1'b0;
      o_irq_out_low_oe <= 1'b0;
    end
    else
    begin
      o_irq_out_low_o <= 1'b0;
      o_irq_out_low_oe <= pending;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      gv[i] = seq_ctrl[i] ? (gpo.level[i] & pin.enable_pin) : gpo.level[i];
      if (ovp_live | top_flag[TF_OVP])
        gv[i] = 1'b0;
    end
    // pin 1 carries power-good when not selected as output
    if (!gpo.out1_function_select)
      gv[1] = i_pg1_level;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_gpo_o <= 3'h0;
      o_gpo_oe <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        o_gpo_o[i] <= gpo.drive_type[i] ? 1'b0 : gv[i];
        o_gpo_oe[i] <= gpo.drive_type[i] ? ~gv[i] : 1'b1;
      end
      // pin 2 left to its clock or watchdog input function
      if (!gpo.out2_function_select)
        o_gpo_oe[2] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        A_CTRL: o_rdata <= ctrl;
        A_INT_CONV: o_rdata <= {2'h0, conv_flag};
        A_INT_TOP: o_rdata <= top_flag;
        A_MASK_CONV: o_rdata <= {2'h0, conv_mask};
        A_MASK_TOP: o_rdata <= top_mask;
        A_STAT: o_rdata <= {ovp_live, db[DB_WARN], run, pin.current_limit};
        A_STAT2: o_rdata <= {4'h0, o_boost_switch_stop, state, tsd_live};
        A_GPO: o_rdata <= gpo;
        A_GPO_SEQ: o_rdata <= {5'h00, seq_ctrl};
        A_PG_STAT: o_rdata <= {2'h0, db[NDB-1:DB_PGB]};
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_uvlo_release;
    pin.uvlo ##1 !pin.uvlo;
  endsequence
  sequence s_clear_short0;
    i_wr && i_addr == A_INT_CONV && i_wdata[3] && !fault[0] && !reg_clear;
  endsequence

  ilim_flag_a: assert property ($rose(conv_flag[0]) |-> $past(db[0] && !starting[0]))
    else $error("buck0 limit flag without qualified limit");
  ilim_sup_a: assert property ((starting[1] || pin.vout_ramp[1]) |=> !$rose(conv_flag[1]))
    else $error("buck1 limit flag during start or ramp");
  short_off_a: assert property ((fault[0] && !reg_clear) |=> (conv_flag[3] && !run[0] && top_flag[TF_BUCKG]))
    else $error("buck0 shutdown not flagged");
  restart_a: assert property ((s_clear_short0 ##1 (allow[0] && !fault[0] && !reg_clear)) |=> run[0])
    else $error("buck0 did not restart after clear");
  boost_stop_a: assert property ((run[2] && pin.boost_low) |=> o_boost_switch_stop)
    else $error("boost kept switching at low output");
  disch_a: assert property (o_discharge[1] |-> $past(ctrl.discharge[1]))
    else $error("discharge without its enable");
  ovp_block_a: assert property ((ovp_live || top_flag[TF_OVP]) |=> (run == 3'h0 && o_gpo_o == 3'h0))
    else $error("converter or output active on over-voltage");
  ovp_hold_a: assert property ((ovp_live && !reg_clear) |=> top_flag[TF_OVP])
    else $error("over-voltage flag cleared while live");
  tsd_block_a: assert property ((tsd_live && !reg_clear) |=> (run == 3'h0 && top_flag[TF_TSD]))
    else $error("thermal shutdown not enforced");
  uvlo_release_a: assert property (s_uvlo_release |=> state == ST_STANDBY)
    else $error("no standby after lockout release");
  rst_flag_a: assert property (pin.uvlo |=> (top_flag[TF_RST] && run == 3'h0))
    else $error("reset flag missing after lockout");
  ecc_ded_a: assert property ((i_ecc_double && !reg_clear) |=> top_flag[TF_DED])
    else $error("double error not flagged");
  irq_pin_a: assert property (pending |=> o_irq_out_low_oe ##0 !o_irq_out_low_o)
    else $error("interrupt pin not low while pending");
endmodule
`default_nettype wire

/* File: sim/cfp_host.sv */
// host model: register port master and the pulled-up interrupt line
`timescale 1ns/1ps
`default_nettype none
module cfp_host (
  input wire logic i_clk, // system clock
  input wire logic i_irq_o, // interrupt drive value
  input wire logic i_irq_oe, // interrupt pull-low enable
  output logic o_irq_line, // resolved interrupt pin level
  output logic [7:0] o_addr, // register address
  output logic [7:0] o_wdata, // write data
  output logic o_wr, // write strobe
  output logic o_rd // read strobe
);
  // open-drain line: the pull-up wins whenever the device lets go
  assign o_irq_line = i_irq_oe ? i_irq_o : 1'b1;
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one-cycle strobe; the port never stalls, so no wait on an answer
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= ~w;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
  endtask
  task automatic clear(input logic [7:0] a, input logic [7:0] bits);
    access(1'b1, a, bits);
  endtask
endmodule
`default_nettype wire

/* File: sim/test_converter_fault_protection.sv */
// self-checking bench for the converter fault protection block
`timescale 1ns/1ps
`default_nettype none
module test_converter_fault_protection;
  import cfp_pkg::*;
  logic clk;
  logic resetn;
  cfp_pins_s pins;
  logic pg1;
  logic ecc_s;
  logic ecc_d;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [7:0] rdata;
  logic [2:0] conv;
  logic [2:0] disch;
  logic stop;
  logic irq_o;
  logic irq_oe;
  logic irq_line;
  logic [2:0] gpo_o;
  logic [2:0] gpo_oe;
  logic [2:0] gpo_lvl;
  logic rd_d;
  logic [7:0] exp_q[$];
  int n_fail;
  int n_checks;
  int cyc;
  int seed;
  // open-drain outputs read high through their pull-ups
  assign gpo_lvl = (gpo_o & gpo_oe) | ~gpo_oe;
  // short counts keep the run brief; expectations below follow them
  cfp_top #(.ILIM_BOOST_CYCLES(40), .MS_CYCLES(50)) dut (
    .i_clk(clk), .i_resetn(resetn), .i_pins(pins), .i_pg1_level(pg1), .i_ecc_single(ecc_s),
    .i_ecc_double(ecc_d), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_conv_enable(conv), .o_discharge(disch), .o_boost_switch_stop(stop), .o_irq_out_low_o(irq_o),
    .o_irq_out_low_oe(irq_oe), .o_gpo_o(gpo_o), .o_gpo_oe(gpo_oe));
  cfp_host host (
    .i_clk(clk), .i_irq_o(irq_o), .i_irq_oe(irq_oe), .o_irq_line(irq_line), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr_s), .o_rd(rd_s));
  always #2.5 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    chk({5'h00, got}, {5'h00, exp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
    rd_d <= rd_s;
  always @(negedge clk)
    if (rd_d === 1'b1)
      chk(rdata, exp_q.pop_front());
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  initial
  begin
    logic [7:0] w;
    clk = 1'b0;
    resetn = 1'b0;
    pins = '0;
    pg1 = 1'b0;
    ecc_s = 1'b0;
    ecc_d = 1'b0;
    rd_d = 1'b0;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    seed = 72760;
    cyc_wait(10);
    resetn <= 1'b1;
    cyc_wait(3);
    chk3({2'h0, irq_line}, 3'h0);
    rd(A_INT_TOP, 8'h08);
    rd(A_CTRL, 8'h70);
    rd(A_STAT2, 8'h02);
    for (int i = 0; i < 3; i++)
      rd(8'h0A + 8'({$random(seed)} % 246), 8'h00);
    ecc_s <= 1'b1;
    ecc_d <= 1'b1;
    @(posedge clk);
    ecc_s <= 1'b0;
    ecc_d <= 1'b0;
    rd(A_INT_TOP, 8'hC8);
    host.clear(A_INT_TOP, 8'hFF);
    cyc_wait(3);
    chk3({2'h0, irq_line}, 3'h1);
    rd(A_INT_TOP, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      w = {2'h3, 6'($random(seed))};
      wr(A_GPO, w);
      cyc_wait(3);
      chk3(gpo_o, w[2:0] & ~w[5:3]);
      chk3(gpo_oe, ~(w[2:0] & w[5:3]));
      rd(A_GPO, w);
    end
    // power-good filters: buck feedback settles before the slower monitor inputs
    pins.pg_buck <= 2'h3;
    pins.pg_mon <= 4'hF;
    cyc_wait(1250);
    rd(A_PG_STAT, 8'h03);
    cyc_wait(1800);
    rd(A_PG_STAT, 8'h3F);
    // level bit 0 set, so pin 0 shows the enable pin when sequenced
    wr(A_GPO, 8'hC1);
    wr(A_GPO_SEQ, 8'h01);
    pins.enable_pin <= 1'b1;
    cyc_wait(5);
    chk3(gpo_lvl, 3'h1);
    pins.enable_pin <= 1'b0;
    cyc_wait(5);
    chk3(gpo_lvl, 3'h0);
    wr(A_GPO_SEQ, 8'h00);
    // buck0 ramps while both bucks sit in current limit
    wr(A_CTRL, 8'h73);
    cyc_wait(60);
    pins.vout_ramp[0] <= 1'b1;
    pins.current_limit[1:0] <= 2'h3;
    cyc_wait(4010);
    rd(A_INT_CONV, 8'h02);
    rd(A_STAT, 8'h1B);
    chk3({2'h0, irq_line}, 3'h0);
    pins.current_limit <= 3'h0;
    pins.vout_ramp <= 2'h0;
    host.clear(A_INT_CONV, 8'h02);
    wr(A_CTRL, 8'h77);
    cyc_wait(60);
    pins.current_limit[2] <= 1'b1;
    cyc_wait(20);
    rd(A_INT_CONV, 8'h00);
    cyc_wait(30);
    rd(A_INT_CONV, 8'h04);
    pins.current_limit[2] <= 1'b0;
    host.clear(A_INT_CONV, 8'h04);
    // high threshold selected, so the low crossing alone stays quiet
    wr(A_CTRL, 8'h7F);
    pins.warn_lo <= 1'b1;
    cyc_wait(4010);
    rd(A_INT_TOP, 8'h00);
    rd(A_STAT, 8'h38);
    wr(A_MASK_TOP, 8'h01);
    pins.warn_hi <= 1'b1;
    cyc_wait(4010);
    rd(A_INT_TOP, 8'h01);
    rd(A_STAT, 8'h78);
    chk3({2'h0, irq_line}, 3'h1);
    wr(A_MASK_TOP, 8'h00);
    cyc_wait(3);
    chk3({2'h0, irq_line}, 3'h0);
    pins.warn_hi <= 1'b0;
    pins.warn_lo <= 1'b0;
    cyc_wait(4010);
    host.clear(A_INT_TOP, 8'h01);
    rd(A_INT_TOP, 8'h00);
    pins.buck_low[0] <= 1'b1;
    cyc_wait(30);
    chk3(conv, 3'h7);
    cyc_wait(30);
    chk3(conv, 3'h6);
    chk3(disch, 3'h1);
    rd(A_INT_CONV, 8'h08);
    rd(A_INT_TOP, 8'h10);
    pins.buck_low[0] <= 1'b0;
    cyc_wait(3);
    host.clear(A_INT_CONV, 8'h08);
    cyc_wait(3);
    chk3(conv, 3'h7);
    pins.boost_low <= 1'b1;
    pins.boost_sag <= 1'b1;
    cyc_wait(5);
    chk3({2'h0, stop}, 3'h1);
    chk3(conv, 3'h7);
    cyc_wait(55);
    chk3(conv, 3'h3);
    rd(A_INT_CONV, 8'h20);
    rd(A_INT_TOP, 8'h30);
    pins.boost_low <= 1'b0;
    pins.boost_sag <= 1'b0;
    host.clear(A_INT_CONV, 8'h20);
    host.clear(A_INT_TOP, 8'hFF);
    wr(A_GPO, 8'hC7);
    pins.overvoltage <= 1'b1;
    cyc_wait(210);
    chk3(conv, 3'h0);
    chk3(gpo_lvl, 3'h0);
    rd(A_INT_TOP, 8'h02);
    rd(A_STAT, 8'h80);
    host.clear(A_INT_TOP, 8'h02);
    rd(A_INT_TOP, 8'h02);
    pins.overvoltage <= 1'b0;
    cyc_wait(210);
    chk3(conv, 3'h0);
    host.clear(A_INT_TOP, 8'h02);
    rd(A_INT_TOP, 8'h00);
    wr(A_CTRL, 8'h70);
    wr(A_CTRL, 8'h71);
    cyc_wait(60);
    chk3(conv, 3'h1);
    pins.thermal_sd <= 1'b1;
    cyc_wait(4010);
    chk3(conv, 3'h0);
    rd(A_STAT2, 8'h03);
    rd(A_INT_TOP, 8'h04);
    host.clear(A_INT_TOP, 8'h04);
    rd(A_INT_TOP, 8'h04);
    pins.thermal_sd <= 1'b0;
    cyc_wait(4010);
    host.clear(A_INT_TOP, 8'h04);
    rd(A_INT_TOP, 8'h00);
    pins.uvlo <= 1'b1;
    cyc_wait(5);
    chk3(conv, 3'h0);
    chk3(disch, 3'h7);
    rd(A_STAT2, 8'h00);
    pins.uvlo <= 1'b0;
    cyc_wait(5);
    rd(A_STAT2, 8'h02);
    rd(A_INT_TOP, 8'h08);
    host.clear(A_INT_TOP, 8'h08);
    wr(A_GPO, 8'h55);
    wr(A_CTRL, 8'h80);
    cyc_wait(3);
    rd(A_GPO, 8'h00);
    rd(A_CTRL, 8'h70);
    rd(A_INT_TOP, 8'h08);
    cyc_wait(3);
    report_and_stop();
  end
endmodule
`default_nettype wire
